// file: src/fpcc_pkg.sv
// package: register map, field positions, reset values and carriers
// ----------------------------------------------------------------------
// Overview of operation
// - auto-preserve enable lets fp instructions set context-active
// - context-active drives hardware save/restore on exceptions
// - auto-preserve enable banked per security state
// - lazy-save enable selects lazy preservation
// - lock set: non-secure lazy-enable writes ignored
// - lock clear: lazy enable writable from both
// - clear-on-return zeroes s0-s15, status on return
// - clear-on-return lock makes clear-on-return read-only from non-secure
// - non-secure sees clear-on-return lock as zero
// - lazy, locks, clear-on-return shared across states
// - lazy-save-active bit zero shows lazy state active
// ----------------------------------------------------------------------
package fpcc_pkg;
    localparam logic [11:0] FPCC_OFS_SECURE     = 12'h000;
    localparam logic [11:0] FPCC_OFS_NONSECURE  = 12'h004;
    localparam logic [11:0] FPCC_OFS_STATUS     = 12'h008;
    localparam int          FPCC_BIT_AUTO_PRESERVE_ENABLE      = 31;
    localparam int          FPCC_BIT_LAZY_SAVE_ENABLE      = 30;
    localparam int          FPCC_BIT_LSLOCK     = 29;
    localparam int          FPCC_BIT_CLR        = 28;
    localparam int          FPCC_BIT_CLRLOCK    = 27;
    localparam int          FPCC_BIT_LSACT      = 0;
    localparam int          FPCC_BIT_FPCA       = 1;
    localparam int          FPCC_BIT_SAVING     = 2;
    localparam int          FPCC_BIT_RESTORING  = 3;
    localparam int          FPCC_BIT_CLEARING   = 4;
    localparam logic        FPCC_RST_AUTO_PRESERVE_ENABLE      = 1'b1;
    localparam logic        FPCC_RST_LAZY_SAVE_ENABLE      = 1'b1;
    localparam logic        FPCC_RST_OTHER      = 1'b0;
    localparam logic [1:0]  FPCC_RESP_OKAY      = 2'b00;
    localparam logic [1:0]  FPCC_RESP_SLVERR    = 2'b10;

    // core-side events that this block reacts to
    typedef struct packed {
        logic fp_instr;
        logic exc_entry;
        logic exc_return;
        logic lazy_done;
    } fpcc_evt_s;

    // commands handed to the fp datapath, one-cycle pulses
    typedef struct packed {
        logic save_full;
        logic save_lazy;
        logic restore;
        logic clear_regs;
    } fpcc_cmd_s;
endpackage

// file: src/fpcc_field_write.sv
// write-merge of four of the upper fields for one access
`timescale 1ns/100ps
module fpcc_field_write
    import fpcc_pkg::*;
(
    input  wire logic        secure,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        lazy_save_enable_cur,
    input  wire logic        lslock_cur,
    input  wire logic        clr_cur,
    input  wire logic        clrlock_cur,
    output logic             lazy_save_enable_new,
    output logic             lslock_new,
    output logic             clr_new,
    output logic             clrlock_new
);
    logic hi;
    always_comb begin
        hi = wstrb[3];
        lazy_save_enable_new   = lazy_save_enable_cur;
        lslock_new  = lslock_cur;
        clr_new     = clr_cur;
        clrlock_new = clrlock_cur;
        if (hi) begin
            if (secure) begin
                // secure side is never locked out
                lazy_save_enable_new   = wdata[FPCC_BIT_LAZY_SAVE_ENABLE];
                lslock_new  = wdata[FPCC_BIT_LSLOCK];
                clr_new     = wdata[FPCC_BIT_CLR];
                clrlock_new = wdata[FPCC_BIT_CLRLOCK];
            end else begin
                if (!lslock_cur) begin
                    lazy_save_enable_new = wdata[FPCC_BIT_LAZY_SAVE_ENABLE];
                end
                if (!clrlock_cur) begin
                    clr_new = wdata[FPCC_BIT_CLR];
                end
                // lock bits are write-ignored from non-secure
            end
        end
    end
endmodule

// file: src/fpcc_top.sv
// fp context control upper fields with axi4-lite register access
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module fpcc_top
    import fpcc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire fpcc_evt_s   evt,
    input  wire logic        core_secure,
    output fpcc_cmd_s        cmd,
    output logic             fp_context_active,
    output logic             lazy_save_active,
    output logic             lazy_save_enable,
    output logic             clear_on_return
);
    import fpcc_pkg::*;

    // ------------------------------------------------------------------
    // field storage
    // ------------------------------------------------------------------
    logic auto_preserve_enable_s_r;
    logic auto_preserve_enable_ns_r;
    logic lazy_save_enable_r;
    logic lslock_r;
    logic clr_r;
    logic clrlock_r;
    logic fpca_r;
    logic lsact_r;

    // ------------------------------------------------------------------
    // axi write channel
    // ------------------------------------------------------------------
    logic        aw_held_r;
    logic        w_held_r;
    logic [11:0] awaddr_r;
    logic        awsec_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        do_write;
    logic        wr_hit;

    // secure view needs both the secure address alias and a clear nonsecure bit
    // of the protection field; either one alone gives the non-secure view
    function automatic logic is_secure(input logic [11:0] a,
                                       input logic [2:0] p);
        is_secure = (a == FPCC_OFS_SECURE) && !p[1];
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a == FPCC_OFS_SECURE) || (a == FPCC_OFS_NONSECURE) ||
                    (a == FPCC_OFS_STATUS);
    endfunction

    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_hit   = do_write && ((awaddr_r == FPCC_OFS_SECURE) ||
                                   (awaddr_r == FPCC_OFS_NONSECURE));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r     <= 1'b0;
            awaddr_r      <= 12'h000;
            awsec_r       <= 1'b0;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_r && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
                awsec_r   <= is_secure(s_axi_awaddr, s_axi_awprot);
                s_axi_awready <= 1'b0;
            end else if (do_write) begin
                aw_held_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r     <= 1'b0;
            wdata_r      <= 32'h0000_0000;
            wstrb_r      <= 4'h0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held_r && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r     <= 1'b1;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (do_write) begin
                w_held_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= FPCC_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? FPCC_RESP_OKAY : FPCC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // field update
    // ------------------------------------------------------------------
    logic lazy_save_enable_nxt;
    logic lslock_nxt;
    logic clr_nxt;
    logic clrlock_nxt;

    fpcc_field_write u_merge (
        .secure      (awsec_r),
        .wdata       (wdata_r),
        .wstrb       (wstrb_r),
        .lazy_save_enable_cur   (lazy_save_enable_r),
        .lslock_cur  (lslock_r),
        .clr_cur     (clr_r),
        .clrlock_cur (clrlock_r),
        .lazy_save_enable_new   (lazy_save_enable_nxt),
        .lslock_new  (lslock_nxt),
        .clr_new     (clr_nxt),
        .clrlock_new (clrlock_nxt)
    );

    // one shared copy of the lazy and clear fields for both states
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lazy_save_enable_r   <= FPCC_RST_LAZY_SAVE_ENABLE;
            lslock_r  <= FPCC_RST_OTHER;
            clr_r     <= FPCC_RST_OTHER;
            clrlock_r <= FPCC_RST_OTHER;
        end else if (wr_hit) begin
            lazy_save_enable_r   <= lazy_save_enable_nxt;
            lslock_r  <= lslock_nxt;
            clr_r     <= clr_nxt;
            clrlock_r <= clrlock_nxt;
        end
    end

    // banked enable: each view writes its own copy
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            auto_preserve_enable_s_r  <= FPCC_RST_AUTO_PRESERVE_ENABLE;
            auto_preserve_enable_ns_r <= FPCC_RST_AUTO_PRESERVE_ENABLE;
        end else if (wr_hit && wstrb_r[3]) begin
            if (awsec_r) begin
                auto_preserve_enable_s_r  <= wdata_r[FPCC_BIT_AUTO_PRESERVE_ENABLE];
            end else begin
                auto_preserve_enable_ns_r <= wdata_r[FPCC_BIT_AUTO_PRESERVE_ENABLE];
            end
        end
    end

    // ------------------------------------------------------------------
    // context tracking and datapath commands
    // ------------------------------------------------------------------
    logic auto_preserve_enable_cur;
    logic clear_ok;
    assign auto_preserve_enable_cur = core_secure ? auto_preserve_enable_s_r : auto_preserve_enable_ns_r;
    assign clear_ok  = clr_r && fpca_r && !lsact_r;

    // an exception entry saves and drops context; a set in the same cycle
    // from an fp instruction loses, since the entry stacks first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fpca_r <= 1'b0;
        end else if (evt.exc_entry && fpca_r) begin
            fpca_r <= 1'b0;
        end else if (evt.fp_instr && auto_preserve_enable_cur) begin
            fpca_r <= 1'b1;
        end
    end

    // lazy-active: set on a lazy entry, cleared when the deferred save
    // completes; a new set beats a same-cycle completion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lsact_r <= 1'b0;
        end else if (evt.exc_entry && fpca_r && lazy_save_enable_r) begin
            lsact_r <= 1'b1;
        end else if (evt.lazy_done) begin
            lsact_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cmd <= '0;
        end else begin
            cmd.save_full  <= evt.exc_entry && fpca_r && !lazy_save_enable_r;
            cmd.save_lazy  <= evt.exc_entry && fpca_r && lazy_save_enable_r;
            cmd.restore    <= evt.exc_return && fpca_r && !clear_ok;
            cmd.clear_regs <= evt.exc_return && clear_ok;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fp_context_active <= 1'b0;
            lazy_save_active  <= 1'b0;
            lazy_save_enable  <= FPCC_RST_LAZY_SAVE_ENABLE;
            clear_on_return   <= FPCC_RST_OTHER;
        end else begin
            fp_context_active <= fpca_r;
            lazy_save_active  <= lsact_r;
            lazy_save_enable  <= lazy_save_enable_r;
            clear_on_return   <= clr_r;
        end
    end

    // ------------------------------------------------------------------
    // axi read channel
    // ------------------------------------------------------------------
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0000_0000;
        if (s_axi_araddr == FPCC_OFS_STATUS) begin
            rd_val[FPCC_BIT_LSACT]     = lsact_r;
            rd_val[FPCC_BIT_FPCA]      = fpca_r;
            rd_val[FPCC_BIT_SAVING]    = cmd.save_full;
            rd_val[FPCC_BIT_RESTORING] = cmd.restore;
            rd_val[FPCC_BIT_CLEARING]  = cmd.clear_regs;
        end else if (is_mapped(s_axi_araddr)) begin
            rd_val[FPCC_BIT_LAZY_SAVE_ENABLE] = lazy_save_enable_r;
            rd_val[FPCC_BIT_LSLOCK] = lslock_r;
            rd_val[FPCC_BIT_CLR]   = clr_r;
            rd_val[FPCC_BIT_LSACT] = lsact_r;
            if (is_secure(s_axi_araddr, s_axi_arprot)) begin
                rd_val[FPCC_BIT_AUTO_PRESERVE_ENABLE]   = auto_preserve_enable_s_r;
                rd_val[FPCC_BIT_CLRLOCK] = clrlock_r;
            end else begin
                rd_val[FPCC_BIT_AUTO_PRESERVE_ENABLE] = auto_preserve_enable_ns_r;
                // lock reads as zero from the non-secure view
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= FPCC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_val;
                s_axi_rresp   <= is_mapped(s_axi_araddr) ?
                                 FPCC_RESP_OKAY : FPCC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// file: test/fpcc_assertions.sv
// checker for the fp context control bus answers and event commands
`timescale 1ns/100ps
module fpcc_assertions
    import fpcc_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire fpcc_evt_s   evt,
    input wire fpcc_cmd_s   cmd,
    input wire logic        fp_context_active,
    input wire logic        lazy_save_active,
    input wire logic        lazy_save_enable,
    input wire logic        clear_on_return
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped early");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("write answer dropped early");
    a_ctx_cause: assert property ($rose(fp_context_active)
        |-> $past(evt.fp_instr) || $past(evt.fp_instr, 2)
            || $past(evt.fp_instr, 3))
        else $error("context active without fp instruction");
    a_entry_saves: assert property (evt.exc_entry && fp_context_active
        |-> ##[1:3] (cmd.save_full || cmd.save_lazy))
        else $error("no save on entry");
    a_entry_drops: assert property ((cmd.save_full || cmd.save_lazy)
        |-> ##[0:2] !fp_context_active)
        else $error("context active kept after save");
    a_return_acts: assert property (evt.exc_return && fp_context_active
        |-> ##[1:3] (cmd.restore || cmd.clear_regs))
        else $error("no restore on return");
    a_lazy_enabled: assert property (cmd.save_lazy |-> lazy_save_enable)
        else $error("lazy save while disabled");
    a_full_disabled: assert property (cmd.save_full |-> !lazy_save_enable)
        else $error("full save while lazy enabled");
    a_lazy_flag: assert property (cmd.save_lazy |-> ##[0:1] lazy_save_active)
        else $error("lazy active flag not set");
    a_clear_gated: assert property (cmd.clear_regs
        |-> clear_on_return && !lazy_save_active)
        else $error("clear without its conditions");
endmodule
bind fpcc_top fpcc_assertions u_chk (.aclk, .aresetn, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .evt, .cmd,
    .fp_context_active, .lazy_save_active, .lazy_save_enable,
    .clear_on_return);

// file: test/fpcc_top_bench.sv
// self-checking bench: register views, locks and fp event commands
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    failures++; $display("BAD %0t got %h want %h", $time, g, e); end end
module fpcc_top_bench;
    import fpcc_pkg::*;
    localparam logic [2:0]  SEC = 3'h0;
    localparam logic [2:0]  NSC = 3'h2;
    localparam logic [31:0] M   = 32'hF800_0000;
    logic        aclk, aresetn, core_secure;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    fpcc_evt_s   evt;
    fpcc_cmd_s   cmd;
    logic        fp_context_active, lazy_save_active;
    logic        lazy_save_enable, clear_on_return;
    int          failures, comparisons;
    int          ncmd [4];

    fpcc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .evt, .core_secure, .cmd, .fp_context_active,
        .lazy_save_active, .lazy_save_enable, .clear_on_return);

    initial begin
        aclk = 1'h0;
        forever #20 aclk = ~aclk;
    end

    // count the one-cycle command pulses
    always @(posedge aclk) begin
        for (int i = 0; i < 4; i++) if (aresetn && cmd[i]) ncmd[i]++;
    end

    task automatic close_out();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // one axi4-lite write (w=1) or read; the response ready is offered
    // with the request and held until the answer is seen
    // ------------------------------------------------------------
    task automatic acc(input bit w, input logic [11:0] a,
        input logic [2:0] p, input logic [31:0] d, input logic [31:0] m,
        input logic [1:0] er);
        int n;
        logic h1, h2, dn;
        logic [1:0] rs;
        logic [31:0] rv;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_awprot <= p;
        s_axi_arprot <= p;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_arvalid <= !w;
        s_axi_bready <= w;
        s_axi_rready <= !w;
        do begin
            // sample at the falling edge: same values the rising edge takes
            @(negedge aclk);
            h1 = w ? s_axi_awvalid && s_axi_awready
                   : s_axi_arvalid && s_axi_arready;
            h2 = s_axi_wvalid && s_axi_wready;
            dn = w ? s_axi_bvalid && s_axi_bready
                   : s_axi_rvalid && s_axi_rready;
            rs = w ? s_axi_bresp : s_axi_rresp;
            rv = s_axi_rdata;
            @(posedge aclk);
            if (h1 && w) s_axi_awvalid <= 1'h0;
            if (h1 && !w) s_axi_arvalid <= 1'h0;
            if (h2) s_axi_wvalid <= 1'h0;
            n++;
        end while (!dn && n < 40);
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
        if (!dn) begin
            failures++;
            close_out();
        end
        `CHK(rs, er)
        if (!w) `CHK(rv & m, d)
    endtask

    task automatic ev(input fpcc_evt_s e);
        @(posedge aclk);
        evt <= e;
        @(posedge aclk);
        evt <= '0;
        repeat (4) @(posedge aclk);
        @(negedge aclk);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {aresetn, core_secure, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hF;
        evt = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        acc(0, 12'h000, SEC, 32'hC000_0000, M, FPCC_RESP_OKAY);
        `CHK(lazy_save_enable, 1'h1)
        acc(0, 12'h00C, SEC, 32'h0, 32'hFFFF_FFFF, FPCC_RESP_SLVERR);
        acc(1, 12'h010, SEC, 32'hFFFF_FFFF, M, FPCC_RESP_SLVERR);
        acc(1, 12'h004, NSC, 32'h0, M, FPCC_RESP_OKAY);
        acc(0, 12'h004, NSC, 32'h0, M, FPCC_RESP_OKAY);
        `CHK(lazy_save_enable, 1'h0)
        acc(0, 12'h000, SEC, 32'h8000_0000, M, FPCC_RESP_OKAY);
        acc(1, 12'h000, SEC, 32'hF800_0000, M, FPCC_RESP_OKAY);
        acc(0, 12'h000, SEC, 32'hF800_0000, M, FPCC_RESP_OKAY);
        acc(0, 12'h004, NSC, 32'h7000_0000, M, FPCC_RESP_OKAY);
        acc(1, 12'h004, NSC, 32'h8000_0000, M, FPCC_RESP_OKAY);
        acc(0, 12'h004, NSC, 32'hF000_0000, M, FPCC_RESP_OKAY);
        acc(0, 12'h000, SEC, 32'hF800_0000, M, FPCC_RESP_OKAY);
        acc(1, 12'h000, SEC, 32'h8000_0000, M, FPCC_RESP_OKAY);
        acc(1, 12'h004, NSC, 32'h0, M, FPCC_RESP_OKAY);
        ev(4'h8);
        `CHK(fp_context_active, 1'h0)
        core_secure <= 1'h1;
        ev(4'h8);
        `CHK(fp_context_active, 1'h1)
        ev(4'h4);
        `CHK(ncmd[3], 1)
        `CHK(fp_context_active, 1'h0)
        ev(4'h8);
        ev(4'h2);
        `CHK(ncmd[1], 1)
        acc(1, 12'h000, SEC, 32'h9000_0000, M, FPCC_RESP_OKAY);
        ev(4'h8);
        ev(4'h2);
        `CHK(ncmd[0], 1)
        acc(1, 12'h000, SEC, 32'hD000_0000, M, FPCC_RESP_OKAY);
        ev(4'h8);
        ev(4'h4);
        `CHK(ncmd[2], 1)
        `CHK(lazy_save_active, 1'h1)
        acc(0, 12'h008, SEC, 32'h1, 32'h1, FPCC_RESP_OKAY);
        ev(4'h8);
        ev(4'h2);
        `CHK(ncmd[1], 2)
        `CHK(ncmd[0], 1)
        ev(4'h1);
        `CHK(lazy_save_active, 1'h0)
        close_out();
    end
endmodule
